// ===== rtl/wdg_device.sv
// Watchdog device: 24-bit down counter, unlock machine, status flags.
// Assumes the core side drives the link strobes synchronous to i_clk.
//
// Notes on behaviour
// [R1] 24-bit down counter, oscillator-timed, reload from three bytes
// [R2] Enable by refresh or always-on; never disabled
// [R3] First enable loads reload value
// [R4] Refresh reloads counter, counting resumes
// [R5] Refresh ignored once counter reaches two
// [R6] Time-out when counter reaches zero
// [R7] Response-select chooses interrupt or reset
// [R8] Interrupt response: request plus time-out flag
// [R9] Interrupt time-out wraps counter to all ones
// [R10] Reset response running: reset plus time-out flag
// [R11] Reset response stopped: recovery, time-out and stop flags
// [R12] Runs in stop mode by default
// [R13] 55, AA, then 81/00 sets stop behaviour
// [R14] 55, AA, upper, high, low changes reload
// [R15] Unlock writes leave control flags unchanged
// [R16] Stray write relocks the sequence
// [R17] Debug mode refreshes continuously
// [R18] Software keeps reload at four or more
// [R19] One decrement per oscillator period
// [R20] Control read clears upper four flags
// [R21] Reload addresses read live counter
// [R22] Low byte write relocks
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wdg_device
    import wdg_pkg::*;
#(
    parameter int TICKS = wdg_pkg::TICK_CYCLES
) (
    input  wire logic  i_clk,
    input  wire logic  i_rst_b,
    wdg_link_if.device link,
    input  wire logic  i_always_on_option,
    input  wire logic  i_timeout_response_select,
    input  wire logic  i_ext_reset_event,
    input  wire logic  i_pin_recovery_event,
    output logic       o_irq,
    output logic       o_reset_req,
    output logic       o_stop_recovery,
    output logic       o_enabled
);
    import wdg_pkg::*;

    typedef enum logic [4:0] {
        LOCKED   = 5'b00001,
        GOT_55   = 5'b00010,
        UNLOCKED = 5'b00100,
        GOT_UP   = 5'b01000,
        GOT_HIGH = 5'b10000
    } wdg_lock_type;

    wdg_lock_type      lock_state;
    wdg_lock_type      next_lock_state;
    logic [23:0]       watchdog_counter;
    logic [23:0]       reload;
    logic [15:0]       div_count;
    logic              tick;
    logic              enabled;
    logic              stop_off;
    logic [3:0]        flags;
    logic              halted;
    logic              refresh_ok;
    logic              timeout;
    logic              ctl_wr;

    // Oscillator halted only when configured off and device stopped
    assign halted     = stop_off & link.stop_mode; // [R12] [R13]
    assign ctl_wr     = link.wr_en & (link.addr == ADDR_CONTROL);
    assign refresh_ok = link.refresh & (watchdog_counter > COUNT_TWO); // [R5]
    // Time-out is the tick that takes the counter from one to zero, or to reload under the reset response
    assign timeout    = enabled & tick & ~link.debug_mode
                        & (watchdog_counter == COUNT_ONE); // [R6]

    // Oscillator modelled as an enable from a divider
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || halted) begin
            div_count <= '0;
            tick      <= 1'b0;
        end else if (div_count == 16'(TICKS - 1)) begin
            div_count <= '0;
            tick      <= 1'b1; // [R19]
        end else begin
            div_count <= div_count + 16'h0001;
            tick      <= 1'b0;
        end
    end

    // Enable latch; nothing clears it short of reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            enabled <= 1'b0;
        end else if (link.refresh || i_always_on_option) begin
            enabled <= 1'b1; // [R2]
        end
    end

    // Counter
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            watchdog_counter <= RELOAD_RESET;
        end else if (!enabled) begin
            watchdog_counter <= reload; // [R3]
        end else if (link.debug_mode) begin
            watchdog_counter <= reload; // [R17]
        end else if (refresh_ok) begin
            watchdog_counter <= reload; // [R4]
        end else if (timeout && i_timeout_response_select) begin
            // Device is being reset; restart from the reload value
            watchdog_counter <= reload; // [R10]
        end else if (tick) begin
            // From zero the decrement wraps to all ones, no reload
            watchdog_counter <= watchdog_counter - COUNT_ONE; // [R1] [R9]
        end
    end

    // Time-out responses
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_irq           <= 1'b0;
            o_reset_req     <= 1'b0;
            o_stop_recovery <= 1'b0;
        end else begin
            o_irq           <= timeout & ~i_timeout_response_select; // [R7] [R8]
            o_reset_req     <= timeout & i_timeout_response_select
                               & ~link.stop_mode; // [R10]
            o_stop_recovery <= timeout & i_timeout_response_select
                               & link.stop_mode; // [R11]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_enabled <= 1'b0;
        end else begin
            o_enabled <= enabled;
        end
    end

    // Status flags; events override a clearing read in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            flags <= FLAGS_RESET;
        end else if (timeout && i_timeout_response_select && link.stop_mode) begin
            flags <= 4'h6; // [R11]
        end else if (timeout && i_timeout_response_select) begin
            flags <= 4'h2; // [R10]
        end else if (timeout) begin
            flags <= {flags[3:2] & {2{~link.rd_en | (link.addr != ADDR_CONTROL)}},
                      1'b1,
                      flags[0] & (~link.rd_en | (link.addr != ADDR_CONTROL))}; // [R8]
        end else if (i_ext_reset_event) begin
            flags <= 4'h1;
        end else if (i_pin_recovery_event) begin
            flags <= 4'h4;
        end else if (link.rd_en && link.addr == ADDR_CONTROL) begin
            flags <= 4'h0; // [R20]
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            link.rdata <= 8'h00;
        end else if (link.rd_en) begin
            unique case (link.addr)
                ADDR_CONTROL: link.rdata <= {flags, 4'h0};
                ADDR_UPPER:   link.rdata <= watchdog_counter[23:16]; // [R21]
                ADDR_HIGH:    link.rdata <= watchdog_counter[15:8]; // [R21]
                ADDR_LOW:     link.rdata <= watchdog_counter[7:0]; // [R21]
            endcase
        end
    end

    // Unlock machine; control writes never touch the flags
    always_comb begin
        next_lock_state = lock_state;
        if (link.wr_en) begin
            next_lock_state = LOCKED; // [R16] [R15]
            unique case (lock_state)
                LOCKED: begin
                    if (ctl_wr && link.wdata == UNLOCK_FIRST) begin
                        next_lock_state = GOT_55;
                    end
                end
                GOT_55: begin
                    if (ctl_wr && link.wdata == UNLOCK_SECOND) begin
                        next_lock_state = UNLOCKED;
                    end
                end
                UNLOCKED: begin
                    if (link.addr == ADDR_UPPER) begin
                        next_lock_state = GOT_UP; // [R14]
                    end
                end
                GOT_UP: begin
                    if (link.addr == ADDR_HIGH) begin
                        next_lock_state = GOT_HIGH; // [R14]
                    end
                end
                GOT_HIGH: begin
                    next_lock_state = LOCKED; // [R22]
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            lock_state <= LOCKED;
        end else begin
            lock_state <= next_lock_state;
        end
    end

    // Reload bytes accepted only in their slot of the sequence
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            reload <= RELOAD_RESET;
        end else if (link.wr_en) begin
            if (lock_state == UNLOCKED && link.addr == ADDR_UPPER) begin
                reload[23:16] <= link.wdata; // [R14]
            end
            if (lock_state == GOT_UP && link.addr == ADDR_HIGH) begin
                reload[15:8] <= link.wdata; // [R14]
            end
            if (lock_state == GOT_HIGH && link.addr == ADDR_LOW) begin
                reload[7:0] <= link.wdata; // [R14]
            end
        end
    end

    // Stop-mode configuration as third step after 55, AA
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            stop_off <= 1'b0; // [R12]
        end else if (lock_state == UNLOCKED && ctl_wr) begin
            if (link.wdata == STOP_OFF_BYTE) begin
                stop_off <= 1'b1; // [R13]
            end else if (link.wdata == STOP_ON_BYTE) begin
                stop_off <= 1'b0; // [R13]
            end
        end
    end
endmodule // wdg_device
`default_nettype wire

// ===== pkg/wdg_pkg.sv
// Shared constants for the watchdog device and its core-side driver.
// Assumes one 125 MHz clock and a synchronous active-low reset.
package wdg_pkg;
    // Link register addresses
    localparam logic [1:0] ADDR_CONTROL   = 2'h0;
    localparam logic [1:0] ADDR_UPPER     = 2'h1;
    localparam logic [1:0] ADDR_HIGH      = 2'h2;
    localparam logic [1:0] ADDR_LOW       = 2'h3;
    // Unlock and stop-mode configuration bytes
    localparam logic [7:0] UNLOCK_FIRST   = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND  = 8'haa;
    localparam logic [7:0] STOP_OFF_BYTE  = 8'h81;
    localparam logic [7:0] STOP_ON_BYTE   = 8'h00;
    // Counter
    localparam int         COUNT_WIDTH    = 24;
    localparam logic [23:0] COUNT_TWO     = 24'h000002;
    localparam logic [23:0] COUNT_ONE     = 24'h000001;
    localparam logic [23:0] COUNT_MAX     = 24'hffffff;
    localparam logic [23:0] RELOAD_RESET  = 24'hffffff;
    // Control register flag positions and reset values
    localparam int         FLAG_POWER_ON  = 7;
    localparam int         FLAG_STOP_REC  = 6;
    localparam int         FLAG_TIMEOUT   = 5;
    localparam int         FLAG_EXTERNAL  = 4;
    localparam logic [3:0] FLAGS_RESET    = 4'h8;
    // Timing
    localparam int         CLK_HZ         = 125_000_000;
    localparam int         OSC_HZ         = 10_000;
    localparam int         TICK_CYCLES    = CLK_HZ / OSC_HZ;
    // APB register offsets of the core-side driver
    localparam logic [7:0] APB_MODE       = 8'h00;
    localparam logic [7:0] APB_REFRESH    = 8'h04;
    localparam logic [7:0] APB_ACCESS     = 8'h08;
    localparam logic [7:0] APB_STATUS     = 8'h0c;
    localparam int         ACC_READ_BIT   = 16;
    localparam int         STAT_BUSY_BIT  = 8;
endpackage

// ===== pkg/wdg_link_if.sv
// Link between the processor core side and the watchdog device.
// Both ends run on the same clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface wdg_link_if;
    logic       wr_en;
    logic       rd_en;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       refresh;
    logic       debug_mode;
    logic       stop_mode;

    modport device (
        input  wr_en, rd_en, addr, wdata, refresh, debug_mode, stop_mode,
        output rdata
    );
    modport host (
        output wr_en, rd_en, addr, wdata, refresh, debug_mode, stop_mode,
        input  rdata
    );
endinterface
`default_nettype wire

// ===== rtl/wdg_host.sv
// Core-side driver: APB slave that issues link writes, reads, refreshes.
// Assumes an APB master on i_clk; reload values below four are refused
// by software, not here.
`timescale 1ns/1ps
`default_nettype none
module wdg_host
    import wdg_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    wdg_link_if.host         link
);
    import wdg_pkg::*;

    logic       busy;
    logic       read_wait;
    logic [7:0] last_read;
    logic       setup;
    logic       mapped;

    assign setup  = i_psel & ~i_penable;
    assign mapped = (i_paddr == APB_MODE) | (i_paddr == APB_REFRESH)
                    | (i_paddr == APB_ACCESS) | (i_paddr == APB_STATUS);

    // Answer in the first access cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup & ~mapped;
            o_prdata  <= 32'h0000_0000;
            if (setup && !i_pwrite) begin
                if (i_paddr == APB_MODE) begin
                    o_prdata <= {30'h0, link.stop_mode, link.debug_mode};
                end else if (i_paddr == APB_STATUS) begin
                    o_prdata <= {23'h0, busy, last_read};
                end
            end
        end
    end

    // Writes take effect at the setup edge, answered one cycle later
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            link.debug_mode <= 1'b0;
            link.stop_mode  <= 1'b0;
        end else if (setup && i_pwrite && i_paddr == APB_MODE) begin
            link.debug_mode <= i_pwdata[0]; // [R17]
            link.stop_mode  <= i_pwdata[1];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            link.refresh <= 1'b0;
        end else begin
            link.refresh <= setup & i_pwrite & (i_paddr == APB_REFRESH); // [R4]
        end
    end

    // One link access at a time; requests while busy are dropped
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            link.wr_en <= 1'b0;
            link.rd_en <= 1'b0;
            link.addr  <= ADDR_CONTROL;
            link.wdata <= 8'h00;
            busy       <= 1'b0;
            read_wait  <= 1'b0;
            last_read  <= 8'h00;
        end else begin
            link.wr_en <= 1'b0;
            link.rd_en <= 1'b0;
            read_wait  <= link.rd_en;
            if (read_wait) begin
                last_read <= link.rdata;
            end
            busy <= link.wr_en | link.rd_en | (read_wait & busy);
            if (read_wait) begin
                busy <= 1'b0;
            end
            if (setup && i_pwrite && i_paddr == APB_ACCESS && !busy) begin
                link.addr  <= i_pwdata[9:8];
                link.wdata <= i_pwdata[7:0]; // [R13] [R14] [R16] [R18]
                link.wr_en <= ~i_pwdata[ACC_READ_BIT];
                link.rd_en <= i_pwdata[ACC_READ_BIT];
                busy       <= 1'b1;
            end
        end
    end
endmodule // wdg_host
`default_nettype wire

// ===== test/wdg_link_props.sv
// Checker for the link between the core-side driver and the watchdog.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wdg_link_props
    import wdg_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [1:0] addr,
    input wire logic [7:0] rdata,
    input wire logic       refresh,
    input wire logic       debug_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic       dbg_rd_q;
    logic       dbg_seen;
    logic [7:0] dbg_val;
    // Debug-mode reads of the low byte; a write may change the reload
    always_ff @(posedge i_clk) begin
        dbg_rd_q <= i_rst_b && rd_en && debug_mode && addr == ADDR_LOW;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !debug_mode || wr_en) dbg_seen <= 1'b0;
        else if (dbg_rd_q) dbg_seen <= 1'b1;
    end
    always_ff @(posedge i_clk) begin
        if (dbg_rd_q) dbg_val <= rdata;
    end
    a_wr_pulse: assert property (wr_en |=> !wr_en)
        else $error("write strobe longer than one cycle");
    a_rd_pulse: assert property (rd_en |=> !rd_en)
        else $error("read strobe longer than one cycle");
    a_ref_pulse: assert property (refresh |=> !refresh)
        else $error("refresh longer than one cycle");
    a_strobe_excl: assert property (!(wr_en && rd_en))
        else $error("read and write strobes together");
    a_access_gap: assert property ((wr_en || rd_en) |=> !(wr_en || rd_en))
        else $error("link accesses back to back");
    a_rdata_hold: assert property (!$past(rd_en) |-> $stable(rdata))
        else $error("read data moved without a read");
    a_ctl_reserved: assert property (rd_en && addr == ADDR_CONTROL |=> rdata[3:0] == 4'h0)
        else $error("control low nibble not zero");
    a_debug_steady: assert property (dbg_rd_q && dbg_seen |-> rdata == dbg_val)
        else $error("counter moved in debug mode");
endmodule // wdg_link_props
`default_nettype wire

// ===== test/watchdog_timer_24bit_tb_top.sv
// Bench: APB orders into the core-side driver, which drives the watchdog.
// Assumes TICKS cut to 4 so that time-outs land within a few hundred cycles.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_24bit_tb_top;
    import wdg_pkg::*;
    localparam int TK = 4;
    logic        i_clk, i_rst_b, psel, penable, pwrite, o_pready, o_pslverr;
    logic        ao, rsel, ext_ev, pin_ev, o_irq, o_reset_req, o_stop_recovery, o_enabled;
    logic [7:0]  paddr, rl;
    logic [31:0] pwdata, o_prdata;
    logic [15:0] lf;
    logic [32:0] exp_rd[$];
    logic [2:0]  exp_ev[$];
    int          err_total, samples_checked, n;
    wdg_link_if link ();
    wdg_host u_wdg_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .link(link));
    wdg_device #(.TICKS(TK)) u_wdg_device (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link),
        .i_always_on_option(ao), .i_timeout_response_select(rsel),
        .i_ext_reset_event(ext_ev), .i_pin_recovery_event(pin_ev), .o_irq(o_irq),
        .o_reset_req(o_reset_req), .o_stop_recovery(o_stop_recovery), .o_enabled(o_enabled));
    wdg_link_props u_wdg_link_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .wr_en(link.wr_en),
        .rd_en(link.rd_en), .addr(link.addr), .rdata(link.rdata), .refresh(link.refresh),
        .debug_mode(link.debug_mode));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic give_up();
        err_total++;
        $display("FAIL %0t: wait ran out", $time);
        report_and_stop();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 20);
        if (k >= 20) give_up();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask
    // Extra edge lets the driver's busy flag clear; busy writes are dropped
    task automatic lw(input logic [1:0] a, input logic [7:0] d);
        apb(1'b1, APB_ACCESS, {22'h0, a, d});
        @(posedge i_clk);
    endtask
    task automatic lr(input logic [1:0] a, input logic [7:0] e);
        apb(1'b1, APB_ACCESS, {15'h0, 1'b1, 6'h0, a, 8'h00});
        @(posedge i_clk);
        exp_rd.push_back({25'h0, e});
        apb(1'b0, APB_STATUS, 32'h0);
    endtask
    task automatic unlock();
        lw(ADDR_CONTROL, UNLOCK_FIRST);
        lw(ADDR_CONTROL, UNLOCK_SECOND);
    endtask
    task automatic wait_ev(input logic [2:0] e, output int k);
        exp_ev.push_back(e);
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while ({o_irq, o_reset_req, o_stop_recovery} === 3'b000 && k < 400);
        if (k >= 400) give_up();
    endtask
    // Watcher: any read answer or response pulse takes the oldest note
    always @(posedge i_clk) begin
        if (psel && penable && !pwrite && o_pready === 1'b1)
            check({o_pslverr, o_prdata}, exp_rd.size() > 0 ? exp_rd.pop_front() : 'x);
        if ({o_irq, o_reset_req, o_stop_recovery} !== 3'b000)
            check({30'h0, o_irq, o_reset_req, o_stop_recovery},
                  exp_ev.size() > 0 ? {30'h0, exp_ev.pop_front()} : 'x);
    end
    initial begin
        err_total = 0;
        samples_checked = 0;
        {i_rst_b, psel, penable, pwrite, ao, rsel, ext_ev, pin_ev} <= 8'h00;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        lf = 16'd22875;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        check({32'h0, o_enabled}, 33'h0);
        lr(ADDR_CONTROL, 8'h80);
        lr(ADDR_CONTROL, 8'h00);
        exp_rd.push_back({1'b1, 32'h0});
        apb(1'b0, 8'h40, 32'h0);
        lf = lfsr(lf);
        rl = 8'h10 | {4'h0, lf[3:0]};
        unlock();
        lw(ADDR_UPPER, 8'h00);
        lw(ADDR_HIGH, 8'h00);
        lw(ADDR_LOW, rl);
        lw(ADDR_LOW, 8'h03);
        lf = lfsr(lf);
        lw(ADDR_CONTROL, UNLOCK_FIRST);
        lw(ADDR_HIGH, lf[7:0]);
        lw(ADDR_CONTROL, UNLOCK_SECOND);
        lw(ADDR_UPPER, 8'h7f);
        apb(1'b1, APB_MODE, 32'h1);
        apb(1'b1, APB_REFRESH, 32'h0);
        lr(ADDR_LOW, rl);
        repeat (40 * TK) @(posedge i_clk);
        lr(ADDR_LOW, rl);
        lr(ADDR_HIGH, 8'h00);
        lr(ADDR_UPPER, 8'h00);
        lr(ADDR_CONTROL, 8'h00);
        check({32'h0, o_enabled}, 33'h1);
        apb(1'b1, APB_MODE, 32'h0);
        wait_ev(3'b100, n);
        check({32'h0, n >= (rl - 1) * TK && n <= (rl + 1) * TK}, 33'h1);
        repeat (TK) @(posedge i_clk);
        lr(ADDR_UPPER, 8'hff);
        lr(ADDR_CONTROL, 8'h20);
        repeat (6) begin
            apb(1'b1, APB_REFRESH, 32'h0);
            repeat (10 * TK) @(posedge i_clk);
        end
        // Second refresh lands while the count is two or below
        apb(1'b1, APB_REFRESH, 32'h0);
        repeat ((rl - 2) * TK) @(posedge i_clk);
        apb(1'b1, APB_REFRESH, 32'h0);
        wait_ev(3'b100, n);
        check({32'h0, n <= 2 * TK}, 33'h1);
        // Let the count wrap off zero, else the next refresh is ignored
        repeat (TK) @(posedge i_clk);
        rsel <= 1'b1;
        apb(1'b1, APB_REFRESH, 32'h0);
        wait_ev(3'b010, n);
        apb(1'b1, APB_MODE, 32'h1);
        lr(ADDR_CONTROL, 8'h20);
        apb(1'b1, APB_MODE, 32'h3);
        apb(1'b1, APB_MODE, 32'h2);
        wait_ev(3'b001, n);
        apb(1'b1, APB_MODE, 32'h3);
        lr(ADDR_CONTROL, 8'h60);
        unlock();
        lw(ADDR_CONTROL, STOP_OFF_BYTE);
        apb(1'b1, APB_MODE, 32'h2);
        repeat (60 * TK) @(posedge i_clk);
        lr(ADDR_LOW, rl);
        lr(ADDR_CONTROL, 8'h00);
        unlock();
        lw(ADDR_CONTROL, STOP_ON_BYTE);
        wait_ev(3'b001, n);
        apb(1'b1, APB_MODE, 32'h3);
        exp_rd.push_back({1'b0, 32'h3});
        apb(1'b0, APB_MODE, 32'h0);
        ext_ev <= 1'b1;
        @(posedge i_clk);
        ext_ev <= 1'b0;
        lr(ADDR_CONTROL, 8'h10);
        pin_ev <= 1'b1;
        @(posedge i_clk);
        pin_ev <= 1'b0;
        lr(ADDR_CONTROL, 8'h40);
        // Second reset with the always-on option: no refresh needed
        ao <= 1'b1;
        rsel <= 1'b0;
        i_rst_b <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk);
        check({32'h0, o_enabled}, 33'h1);
        lr(ADDR_CONTROL, 8'h80);
        report_and_stop();
    end
endmodule // watchdog_timer_24bit_tb_top
`default_nettype wire
